// ===== logic/uri_usart.sv
// USART with a byte-wide register port, a transmit buffer and a two-entry receive buffer.
// Assumes a 50 MHz core clock, synchronous reset, and a serial partner on txd/rxd/xck.
`include "uri_params.svh"
`default_nettype none
module uri_usart (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt requests
  input wire logic global_irq_enable_i,
  input wire logic txc_irq_ack_i,
  output logic rxc_irq_o,
  output logic txc_irq_o,
  output logic dre_irq_o,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic rxd_own_o,
  output logic xck_o,
  output logic xck_oe_o
);
  import uri_pkg::*;

  localparam logic [7:0] FRAME_RST = `URI_RST_FRAME;

  // Number of data bits for a size code; reserved codes fall back to eight
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: return 4'h5;
      3'h1: return 4'h6;
      3'h2: return 4'h7;
      3'h3: return 4'h8;
      3'h7: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction : char_bits

  // Start bit, data LSB first, optional parity, then idle ones as stop bits
  function automatic logic [12:0] tx_frame(input uri_char_t d, input logic [3:0] n,
                                           input logic pen, input logic podd);
    logic [12:0] f;
    logic p;
    f = 13'h1fff;
    f[0] = 1'b0;
    p = podd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i + 1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pen) begin
      f[n + 4'h1] = p;
    end
    return f;
  endfunction : tx_frame

  // Control registers
  logic rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, csz2_q, txb8_q;
  logic u2x_q, mpcm_q, txc_q, dor_q;
  logic umsel_q, usbs_q, ucpol_q;
  logic [1:0] upm_q;
  logic [1:0] csz_q;
  logic [11:0] ubrr_q;
  logic [11:0] presc_q;
  logic [7:0] rdata_q;

  // Decoded accesses
  logic wr_stat, wr_ctrl, wr_frame, wr_baud_l, wr_baud_h, wr_data, rd_data;
  assign wr_stat = reg_we_i && (reg_addr_i == `URI_OFS_STATUS_A);
  assign wr_ctrl = reg_we_i && (reg_addr_i == `URI_OFS_CONTROL_B);
  assign wr_frame = reg_we_i && (reg_addr_i == `URI_OFS_FRAME);
  assign wr_baud_l = reg_we_i && (reg_addr_i == `URI_OFS_BAUD_L);
  assign wr_baud_h = reg_we_i && (reg_addr_i == `URI_OFS_BAUD_H);
  assign wr_data = reg_we_i && (reg_addr_i == `URI_OFS_DATA);
  assign rd_data = reg_re_i && (reg_addr_i == `URI_OFS_DATA);

  // Frame format
  logic [3:0] nbits;
  logic par_en;
  logic [4:0] os_len;
  assign nbits = char_bits({csz2_q, csz_q});
  assign par_en = upm_q[1];
  assign os_len = u2x_q ? `URI_OS_DOUBLE : `URI_OS_NORMAL;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, csz2_q, txb8_q} <= 7'h00;
    end else if (wr_ctrl) begin
      rxcie_q <= reg_wdata_i[`URI_BIT_RXCIE];
      txcie_q <= reg_wdata_i[`URI_BIT_TXCIE];
      udrie_q <= reg_wdata_i[`URI_BIT_UDRIE];
      rxen_q <= reg_wdata_i[`URI_BIT_RXEN];
      txen_q <= reg_wdata_i[`URI_BIT_TXEN];
      csz2_q <= reg_wdata_i[`URI_BIT_CSZ2];
      txb8_q <= reg_wdata_i[`URI_BIT_TXB8];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      u2x_q <= 1'b0;
      mpcm_q <= 1'b0;
    end else if (wr_stat) begin
      u2x_q <= reg_wdata_i[`URI_BIT_U2X];
      mpcm_q <= reg_wdata_i[`URI_BIT_MPCM];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      umsel_q <= FRAME_RST[`URI_BIT_UMSEL];
      upm_q <= FRAME_RST[`URI_BIT_UPM_HI:`URI_BIT_UPM_LO];
      usbs_q <= FRAME_RST[`URI_BIT_USBS];
      csz_q <= FRAME_RST[`URI_BIT_CSZ_HI:`URI_BIT_CSZ_LO];
      ucpol_q <= FRAME_RST[`URI_BIT_UCPOL];
    end else if (wr_frame) begin
      umsel_q <= reg_wdata_i[`URI_BIT_UMSEL];
      upm_q <= reg_wdata_i[`URI_BIT_UPM_HI:`URI_BIT_UPM_LO];
      usbs_q <= reg_wdata_i[`URI_BIT_USBS];
      csz_q <= reg_wdata_i[`URI_BIT_CSZ_HI:`URI_BIT_CSZ_LO];
      ucpol_q <= reg_wdata_i[`URI_BIT_UCPOL];
    end
  end

  // divisor halves, reserved high bits dropped
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ubrr_q <= `URI_RST_BAUD;
    end else if (wr_baud_l) begin
      ubrr_q[7:0] <= reg_wdata_i;
    end else if (wr_baud_h) begin
      ubrr_q[11:8] <= reg_wdata_i[3:0];
    end
  end

  // prescaler reload on low byte write
  logic tick;
  assign tick = (presc_q == 12'h000) && !wr_baud_l;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      presc_q <= `URI_RST_BAUD;
    end else if (wr_baud_l) begin
      presc_q <= {ubrr_q[11:8], reg_wdata_i};
    end else if (presc_q == 12'h000) begin
      presc_q <= ubrr_q;
    end else begin
      presc_q <= presc_q - 12'h001;
    end
  end

  logic xck_q, tx_edge_sync, rx_edge_sync;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !umsel_q) begin
      xck_q <= 1'b0;
    end else if (tick) begin
      xck_q <= !xck_q;
    end
  end
  assign tx_edge_sync = umsel_q && tick && (ucpol_q ? xck_q : !xck_q);
  assign rx_edge_sync = umsel_q && tick && (ucpol_q ? !xck_q : xck_q);

  // Pin synchroniser
  logic rxd_meta_q, rxd_q;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rxd_meta_q <= 1'b1;
      rxd_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_i;
      rxd_q <= rxd_meta_q;
    end
  end

  // Transmit side
  logic [4:0] tx_os_q;
  logic tx_bit_ce;
  logic txbuf_full_q, tx_busy_q, tx_own_q, tx_load, tx_done;
  uri_char_t txbuf_q;
  logic [12:0] txsh_q;
  logic [3:0] tx_left_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_os_q <= 5'd0;
    end else if (tick) begin
      tx_os_q <= (tx_os_q >= os_len - 5'd1) ? 5'd0 : tx_os_q + 5'd1;
    end
  end
  assign tx_bit_ce = umsel_q ? tx_edge_sync : (tick && tx_os_q >= os_len - 5'd1);

  // load buffered data into the shifter when idle or on its last bit
  assign tx_load = tx_bit_ce && tx_own_q && txbuf_full_q
                   && (!tx_busy_q || tx_left_q == 4'h1);
  assign tx_done = tx_bit_ce && tx_busy_q && tx_left_q == 4'h1 && !tx_load;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      txbuf_full_q <= 1'b0;
      txbuf_q <= '0;
    // write only accepted into an empty buffer
    end else if (wr_data && !txbuf_full_q) begin
      txbuf_full_q <= 1'b1;
      // ninth bit taken as last written
      txbuf_q <= {txb8_q, reg_wdata_i};
    end else if (tx_load) begin
      txbuf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      txsh_q <= 13'h1fff;
      tx_busy_q <= 1'b0;
      tx_left_q <= 4'h0;
    end else if (tx_load) begin
      // frame built from used bits and parity
      txsh_q <= tx_frame(txbuf_q, nbits, par_en, upm_q[0]);
      tx_busy_q <= 1'b1;
      tx_left_q <= 4'h2 + nbits + {3'h0, par_en} + {3'h0, usbs_q};
    end else if (tx_bit_ce && tx_busy_q) begin
      txsh_q <= {1'b1, txsh_q[12:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_busy_q <= (tx_left_q != 4'h1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_own_q <= 1'b0;
    end else if (txen_q) begin
      tx_own_q <= 1'b1;
    end else if (!tx_busy_q && !txbuf_full_q) begin
      tx_own_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      txc_q <= 1'b0;
    end else if (tx_done) begin
      txc_q <= 1'b1;
    end else if (txc_irq_ack_i || (wr_stat && reg_wdata_i[`URI_BIT_TXC])) begin
      txc_q <= 1'b0;
    end
  end

  // Receive side
  uri_rx_state_e rx_state_q;
  logic [4:0] rx_os_q;
  logic [3:0] rx_idx_q, rx_stop_idx;
  uri_char_t rx_sh_q;
  logic rx_pbit_q, rx_sample, rx_start, rx_done, rx_keep, rx_addr;
  uri_rx_entry_s rx_entry, pend_entry_q, head;
  logic pend_q, fifo_full, fifo_empty;
  logic rx_flush;
  assign rx_flush = !rxen_q || (wr_ctrl && !reg_wdata_i[`URI_BIT_RXEN]);

  assign rx_stop_idx = nbits + {3'h0, par_en} + 4'h1;
  assign rx_sample = umsel_q ? rx_edge_sync
                     : (tick && rx_os_q == (os_len >> 1) - 5'd1);
  assign rx_start = rxen_q && rx_state_q == URI_RX_IDLE && !rxd_q
                    && (!umsel_q || rx_edge_sync);
  assign rx_done = rx_state_q == URI_RX_BITS && rx_sample && rx_idx_q == rx_stop_idx;

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rxen_q) begin
      rx_state_q <= URI_RX_IDLE;
      rx_os_q <= 5'd0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= '0;
      rx_pbit_q <= 1'b0;
    end else if (rx_start) begin
      rx_state_q <= URI_RX_BITS;
      rx_os_q <= 5'd0;
      // Synchronous start bit is already sampled
      rx_idx_q <= umsel_q ? 4'h1 : 4'h0;
      rx_sh_q <= '0;
    end else if (rx_state_q == URI_RX_BITS) begin
      if (tick) begin
        rx_os_q <= (rx_os_q >= os_len - 5'd1) ? 5'd0 : rx_os_q + 5'd1;
      end
      if (rx_sample) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && rxd_q) begin
          // False start: line back high at mid bit
          rx_state_q <= URI_RX_IDLE;
        end else if (rx_idx_q == rx_stop_idx) begin
          rx_state_q <= URI_RX_IDLE;
        end else if (rx_idx_q != 4'h0 && rx_idx_q <= nbits) begin
          rx_sh_q[rx_idx_q - 4'h1] <= rxd_q;
        end else if (rx_idx_q != 4'h0) begin
          rx_pbit_q <= rxd_q;
        end
      end
    end
  end

  // error bits captured with the character
  always_comb begin
    rx_entry.data = rx_sh_q;
    rx_entry.fe = !rxd_q;
    rx_entry.pe = par_en && ((^rx_sh_q ^ upm_q[0]) != rx_pbit_q);
  end

  // drop frames without the address marker
  assign rx_addr = (nbits == 4'h9) ? rx_sh_q[8] : rxd_q;
  assign rx_keep = rx_done && (!mpcm_q || rx_addr);

  // Character held in pend_entry_q while the buffer is full
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rx_flush) begin
      pend_q <= 1'b0;
      pend_entry_q <= '0;
    end else if (rx_keep && (fifo_full || pend_q)) begin
      pend_q <= 1'b1;
      pend_entry_q <= rx_entry;
    end else if (pend_q && !fifo_full) begin
      pend_q <= 1'b0;
    end
  end

  // overrun set wins over read, disable clears
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rx_flush) begin
      dor_q <= 1'b0;
    end else if (rx_start && fifo_full && pend_q) begin
      dor_q <= 1'b1;
    end else if (rd_data) begin
      dor_q <= 1'b0;
    end
  end

  // two-entry buffer, popped by data reads, flushed on disable
  uri_rx_fifo #(
    .WIDTH($bits(uri_rx_entry_s)),
    .DEPTH(2)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .flush_i(rx_flush),
    .push_i(pend_q || rx_keep),
    .push_data_i(pend_q ? pend_entry_q : rx_entry),
    .pop_i(rd_data),
    .head_o(head),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  // Register read path, answer one cycle after the strobe
  logic [7:0] status_a, control_b;
  assign status_a = {!fifo_empty, txc_q, !txbuf_full_q, head.fe && !fifo_empty, dor_q,
                     head.pe && !fifo_empty, u2x_q, mpcm_q};
  assign control_b = {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, csz2_q,
                      head.data[8] && !fifo_empty, txb8_q};

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !reg_re_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_i)
        `URI_OFS_STATUS_A: rdata_q <= status_a;
        `URI_OFS_CONTROL_B: rdata_q <= control_b;
        `URI_OFS_FRAME: rdata_q <= {1'b0, umsel_q, upm_q, usbs_q, csz_q, ucpol_q};
        `URI_OFS_BAUD_L: rdata_q <= ubrr_q[7:0];
        `URI_OFS_BAUD_H: rdata_q <= {4'h0, ubrr_q[11:8]};
        // data read returns receive buffer head
        `URI_OFS_DATA: rdata_q <= fifo_empty ? 8'h00 : head.data[7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_o = rdata_q;

  assign rxc_irq_o = rxcie_q && global_irq_enable_i && !fifo_empty;
  assign txc_irq_o = txcie_q && global_irq_enable_i && txc_q;
  assign dre_irq_o = udrie_q && global_irq_enable_i && !txbuf_full_q;

  assign txd_o = txsh_q[0];
  assign txd_oe_o = tx_own_q;
  assign rxd_own_o = rxen_q;
  assign xck_o = xck_q;
  assign xck_oe_o = umsel_q;
endmodule : uri_usart
`default_nettype wire

// ===== shared/uri_params.svh
// Offsets, field positions, reset values and rate constants of the USART register block.
// Included by the package users; holds definitions only.
`ifndef URI_PARAMS_SVH
`define URI_PARAMS_SVH

`define URI_OFS_STATUS_A 8'hc0
`define URI_OFS_CONTROL_B 8'hc1
`define URI_OFS_FRAME 8'hc2
`define URI_OFS_BAUD_L 8'hc4
`define URI_OFS_BAUD_H 8'hc5
`define URI_OFS_DATA 8'hc6

`define URI_BIT_RXC 7
`define URI_BIT_TXC 6
`define URI_BIT_DRE 5
`define URI_BIT_FE 4
`define URI_BIT_DOR 3
`define URI_BIT_PE 2
`define URI_BIT_U2X 1
`define URI_BIT_MPCM 0

`define URI_BIT_RXCIE 7
`define URI_BIT_TXCIE 6
`define URI_BIT_UDRIE 5
`define URI_BIT_RXEN 4
`define URI_BIT_TXEN 3
`define URI_BIT_CSZ2 2
`define URI_BIT_RXB8 1
`define URI_BIT_TXB8 0

`define URI_BIT_UMSEL 6
`define URI_BIT_UPM_HI 5
`define URI_BIT_UPM_LO 4
`define URI_BIT_USBS 3
`define URI_BIT_CSZ_HI 2
`define URI_BIT_CSZ_LO 1
`define URI_BIT_UCPOL 0

`define URI_RST_FRAME 8'h06
`define URI_RST_BAUD 12'h000

`define URI_OS_NORMAL 5'd16
`define URI_OS_DOUBLE 5'd8

`endif

// ===== shared/uri_pkg.sv
// Types shared by the USART register block and its receive buffer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package uri_pkg;
  typedef logic [8:0] uri_char_t;
  typedef struct packed {
    logic pe;
    logic fe;
    uri_char_t data;
  } uri_rx_entry_s;
  typedef enum {URI_RX_IDLE, URI_RX_BITS} uri_rx_state_e;
endpackage : uri_pkg
`default_nettype wire

// ===== logic/uri_rx_fifo.sv
// Small shift FIFO for received characters; the head entry is a register.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module uri_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Control
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  // State
  output logic [WIDTH-1:0] head_o,
  output logic full_o,
  output logic empty_o
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0] cnt_q;
  logic push_ok;
  logic pop_ok;

  assign full_o = (cnt_q == CW'(DEPTH));
  assign empty_o = (cnt_q == '0);
  assign push_ok = push_i && !full_o;
  assign pop_ok = pop_i && !empty_o;
  assign head_o = mem_q[0];

  always_ff @(posedge core_clk_i) begin
    if (srst_i || flush_i) begin
      cnt_q <= '0;
    end else if (push_ok && !pop_ok) begin
      cnt_q <= cnt_q + CW'(1);
    end else if (pop_ok && !push_ok) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        mem_q[i] <= '0;
      end else if (pop_ok) begin
        if (push_ok && CW'(i) == cnt_q - CW'(1)) begin
          mem_q[i] <= push_data_i;
        end else if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
        end
      end else if (push_ok && CW'(i) == cnt_q) begin
        mem_q[i] <= push_data_i;
      end
    end
  end
endmodule : uri_rx_fifo
`default_nettype wire

// ===== testbench/uri_usart_monitor.sv
// Port-level assertions for the USART register block.
// Assumes one clock, synchronous active-high reset and async bits of at least 8 cycles.
`default_nettype none
module uri_usart_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // Interrupts
  input wire logic global_irq_enable_i,
  input wire logic rxc_irq_o,
  input wire logic txc_irq_o,
  input wire logic dre_irq_o,
  // Serial pins
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic rxd_own_o,
  input wire logic xck_oe_o
);
  logic any_irq;
  assign any_irq = rxc_irq_o || txc_irq_o || dre_irq_o;

  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence status_rd;
    reg_re_i && reg_addr_i == 8'hc0;
  endsequence
  sequence ctrl_wr;
    reg_we_i && reg_addr_i == 8'hc1;
  endsequence
  sequence data_wr;
    reg_we_i && reg_addr_i == 8'hc6;
  endsequence
  sequence frame_wr;
    reg_we_i && reg_addr_i == 8'hc2;
  endsequence

  rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  rxc_flag_a: assert property (status_rd ##0 rxc_irq_o |=> reg_rdata_o[7])
    else $error("receive complete not shown");
  txc_flag_a: assert property (status_rd ##0 txc_irq_o |=> reg_rdata_o[6])
    else $error("transmit complete not shown");
  dre_flag_a: assert property (status_rd ##0 dre_irq_o |=> reg_rdata_o[5])
    else $error("data empty not shown");
  irq_gate_a: assert property (any_irq |-> global_irq_enable_i)
    else $error("interrupt without global enable");
  dre_fill_a: assert property (data_wr ##0 dre_irq_o |=> !dre_irq_o)
    else $error("data write left buffer empty");
  rx_own_a: assert property (ctrl_wr |=> rxd_own_o == $past(reg_wdata_i[4]))
    else $error("receive pin ownership wrong");
  tx_own_a: assert property (ctrl_wr ##0 reg_wdata_i[3] |=> ##1 txd_oe_o)
    else $error("transmit pin not taken");
  tx_idle_a: assert property (!txd_oe_o |-> txd_o)
    else $error("released transmit pin not idle");
  rx_flush_a: assert property (ctrl_wr ##0 !reg_wdata_i[4] |=> !rxc_irq_o)
    else $error("receive buffer not flushed");
  xck_mode_a: assert property (frame_wr |=> xck_oe_o == $past(reg_wdata_i[6]))
    else $error("mode select not applied");
  start_len_a: assert property ($fell(txd_o) |-> (!txd_o) [*8])
    else $error("start bit too short");
endmodule : uri_usart_monitor

bind uri_usart uri_usart_monitor u_mon (.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .global_irq_enable_i, .rxc_irq_o, .txc_irq_o,
  .dre_irq_o, .txd_o, .txd_oe_o, .rxd_own_o, .xck_oe_o);
`default_nettype wire

// ===== testbench/uri_partner.sv
// Remote serial transceiver: captures frames from txd and sends frames on rxd.
// Assumes async framing, LSB first, bit length given in core clock cycles.
`default_nettype none
module uri_partner (
  // Clock
  input wire logic core_clk_i,
  // Serial lines
  input wire logic txd_i,
  output logic rxd_o,
  // Frame shape
  input wire logic [7:0] bit_cyc_i,
  input wire logic [3:0] nbits_i,
  input wire logic [1:0] par_i,
  // Captured character
  output logic [8:0] cap_data_o,
  output logic cap_par_ok_o,
  output logic cap_stb_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] sh;
  logic [8:0] mask;
  assign mask = 9'h1ff >> (4'h9 - nbits_i);

  initial begin
    rxd_o = 1'b1;
    cap_stb_o = 1'b0;
    cap_data_o = 9'h000;
    cap_par_ok_o = 1'b0;
    forever begin
      @(negedge txd_i);
      repeat (bit_cyc_i / 2) @(posedge core_clk_i);
      for (int i = 0; i < nbits_i + par_i[1]; i++) begin
        repeat (bit_cyc_i) @(posedge core_clk_i);
        sh[i] = txd_i;
      end
      cap_data_o <= sh[8:0] & mask;
      cap_par_ok_o <= !par_i[1] || ((^(sh[8:0] & mask) ^ sh[nbits_i]) == par_i[0]);
      repeat (bit_cyc_i) @(posedge core_clk_i);
      cap_stb_o <= 1'b1;
      @(posedge core_clk_i);
      cap_stb_o <= 1'b0;
    end
  end

  task automatic send(input logic [8:0] d, input logic bad_par, input logic stop);
    rxd_o <= 1'b0;
    repeat (bit_cyc_i) @(posedge core_clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      rxd_o <= d[i];
      repeat (bit_cyc_i) @(posedge core_clk_i);
    end
    if (par_i[1]) begin
      rxd_o <= ^(d & mask) ^ par_i[0] ^ bad_par;
      repeat (bit_cyc_i) @(posedge core_clk_i);
    end
    rxd_o <= stop;
    repeat (bit_cyc_i) @(posedge core_clk_i);
    rxd_o <= 1'b1;
    repeat (2) @(posedge core_clk_i);
  endtask : send
endmodule : uri_partner
`default_nettype wire

// ===== testbench/uri_usart_test.sv
// Self-checking bench for the USART register block against a serial partner.
// Assumes divisor 0 (16-cycle bits) except where the rate table changes it.
`default_nettype none
module uri_usart_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic srst_i, reg_we_i, reg_re_i, global_irq_enable_i, txc_irq_ack_i, rxd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bit_cyc;
  logic rxc_irq_o, txc_irq_o, dre_irq_o, txd_o, txd_oe_o, rxd_own_o, xck_o, xck_oe_o;
  logic [3:0] n;
  logic [1:0] par;
  logic [8:0] cap_data, d, e, m9;
  logic cap_ok, cap_stb;
  logic rd_pend = 1'b0;
  logic [2:0] c;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [7:0] exp_q [$];
  logic [7:0] msk_q [$];
  logic [8:0] tx_q [$];
  logic [7:0] lfsr = 8'h2a;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  uri_usart dut (.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .global_irq_enable_i, .txc_irq_ack_i, .rxc_irq_o, .txc_irq_o, .dre_irq_o,
    .rxd_i, .txd_o, .txd_oe_o, .rxd_own_o, .xck_o, .xck_oe_o);
  uri_partner u_far (.core_clk_i, .txd_i(txd_o), .rxd_o(rxd_i), .bit_cyc_i(bit_cyc),
    .nbits_i(n), .par_i(par), .cap_data_o(cap_data), .cap_par_ok_o(cap_ok),
    .cap_stb_o(cap_stb));

  always #10 core_clk_i = ~core_clk_i;

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] x, input logic [7:0] m);
    check_count++;
    if ((g & m) !== (x & m)) begin
      num_errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, g, x);
    end
  endtask : cmp_reg

  task automatic cmp_tx(input logic [8:0] g, input logic ok);
    logic [8:0] x;
    x = (tx_q.size() > 0) ? tx_q.pop_front() : ~g;
    check_count++;
    if (g !== x || ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t serial char %h expected %h", $time, g, x);
    end
  endtask : cmp_tx

  task automatic nop(input int k);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    repeat (k) @(posedge core_clk_i);
  endtask : nop

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_we_i <= 1'b1;
    reg_re_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(x);
    msk_q.push_back(m);
    @(posedge core_clk_i);
  endtask : rd

  task automatic snd(input logic [8:0] v, input logic bad, input logic stop);
    nop(1);
    u_far.send(v, bad, stop);
  endtask : snd

  task automatic tx1(input logic [8:0] v);
    tx_q.push_back(v & m9);
    wr(8'hc6, v[7:0]);
    wr(8'hc6, ~v[7:0]);
    nop(1);
    while (tx_q.size() > 0) nop(1);
  endtask : tx1

  task automatic wait_irq(input logic k);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((k ? txc_irq_o : rxc_irq_o) === 1'b1) break;
      nop(1);
    end
    if (i == 3000) begin
      num_errors++;
      $display("[FAIL] %0t interrupt wait timed out", $time);
    end
  endtask : wait_irq

  always @(posedge core_clk_i) begin
    rd_pend <= reg_re_i;
    cycles <= cycles + 1;
    if (cap_stb === 1'b1) cmp_tx(cap_data, cap_ok);
    if (cycles == 40000) begin
      num_errors++;
      $display("[FAIL] %0t run timed out", $time);
      summarize();
    end
  end

  // Read data stand in the cycle after the strobe
  always @(negedge core_clk_i) begin
    if (rd_pend === 1'b1) cmp_reg(reg_rdata_o, exp_q.pop_front(), msk_q.pop_front());
  end

  initial begin
    srst_i = 1'b1;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    global_irq_enable_i = 1'b0;
    txc_irq_ack_i = 1'b0;
    bit_cyc = 8'h10;
    n = 4'h8;
    par = 2'b00;
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(8'hc0, 8'h20, 8'hff);
    rd(8'hc2, 8'h06, 8'hff);
    rd(8'hc4, 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'hff);
    wr(8'hc5, 8'hff);
    rd(8'hc5, 8'h0f, 8'hff);
    wr(8'hc5, 8'h00);
    wr(8'hc4, 8'h00);
    wr(8'hc2, 8'h46);
    wr(8'hc2, 8'h06);
    global_irq_enable_i <= 1'b1;
    foreach (codes[i]) begin
      c = codes[i];
      n = (c == 3'h7) ? 4'h9 : {2'b00, c[1:0]} + 4'h5;
      m9 = 9'h1ff >> (4'h9 - n);
      lfsr = nxt(lfsr);
      d = {lfsr[3], lfsr};
      wr(8'hc2, {5'h00, c[1:0], 1'b0});
      wr(8'hc1, {5'h1f, c[2], 1'b0, d[8]});
      tx1(d);
      wait_irq(1'b1);
      rd(8'hc0, 8'h60, 8'hff);
      if (c[0]) wr(8'hc0, 8'h40);
      else begin
        txc_irq_ack_i <= 1'b1;
        nop(1);
        txc_irq_ack_i <= 1'b0;
      end
      rd(8'hc0, 8'h20, 8'hff);
      lfsr = nxt(lfsr);
      e = {lfsr[5], lfsr};
      snd(e, 1'b0, 1'b1);
      wait_irq(1'b0);
      rd(8'hc1, {5'h1f, c[2], e[8], d[8]}, (n == 4'h9) ? 8'hff : 8'hfd);
      rd(8'hc6, e[7:0] & m9[7:0], 8'hff);
      rd(8'hc0, 8'h20, 8'hff);
    end
    n = 4'h8;
    m9 = 9'h0ff;
    wr(8'hc1, 8'hf8);
    for (int p = 2; p < 4; p++) begin
      par = p[1:0];
      wr(8'hc2, {2'b00, par, 4'h6});
      lfsr = nxt(lfsr);
      tx1({1'b0, lfsr});
      snd({1'b0, ~lfsr}, 1'b1, 1'b1);
      wait_irq(1'b0);
      rd(8'hc0, 8'ha4, 8'hbf);
      rd(8'hc6, ~lfsr, 8'hff);
      rd(8'hc0, 8'h20, 8'hbf);
    end
    par = 2'b00;
    wr(8'hc2, 8'h06);
    snd(9'h05a, 1'b0, 1'b0);
    wait_irq(1'b0);
    rd(8'hc0, 8'hb0, 8'hbf);
    rd(8'hc6, 8'h5a, 8'hff);
    rd(8'hc0, 8'h20, 8'hbf);
    wr(8'hc0, 8'h01);
    snd(9'h033, 1'b0, 1'b0);
    snd(9'h055, 1'b0, 1'b1);
    wait_irq(1'b0);
    rd(8'hc6, 8'h55, 8'hff);
    wr(8'hc0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      e = 9'h0a0 + k[8:0];
      snd(e, 1'b0, 1'b1);
    end
    rd(8'hc0, 8'ha8, 8'hbf);
    rd(8'hc6, 8'ha0, 8'hff);
    nop(1);
    rd(8'hc6, 8'ha1, 8'hff);
    global_irq_enable_i <= 1'b0;
    nop(2);
    global_irq_enable_i <= 1'b1;
    wr(8'hc1, 8'he8);
    rd(8'hc0, 8'h20, 8'hbf);
    wr(8'hc1, 8'hf8);
    for (int k = 0; k < 3; k++) begin
      bit_cyc = (k == 0) ? 8'h20 : ((k == 1) ? 8'h08 : 8'h10);
      wr(8'hc4, {7'h00, k == 0});
      wr(8'hc0, {6'h00, k == 1, 1'b0});
      lfsr = nxt(lfsr);
      tx1({1'b0, lfsr});
    end
    lfsr = nxt(lfsr);
    tx_q.push_back({1'b0, lfsr});
    wr(8'hc6, lfsr);
    wr(8'hc1, 8'hf0);
    nop(1);
    while (tx_q.size() > 0) nop(1);
    nop(40);
    summarize();
  end
endmodule : uri_usart_test
`default_nettype wire
